/* src/mdcb_pkg.sv */
// Constants, register layout and carrier types of the metering DSP control bank.
// Assumes an APB master on one 25 MHz clock and a DSP core that consumes the fields.
//
// What this block does
// - Apparent energy uses RMS or vectorial power; vectorial uses fundamental or active.
// - Per-channel voltage and current bits bypass the high-pass filter when set.
// - Per-channel bit inserts the coil integrator into the current path when set.
// - Voltage and current bits choose fundamental or wideband content for reactive power.
// - Four-bit pulse divider per output, 2^-4 at 0x0 to 2^11 at 0xF, reset 0x4.
// - Two-bit quantity select: active, fundamental, reactive, apparent power.
// - Two-bit source select: primary, secondary, algebraic, raw bitstream.
// - Four-bit field per channel sets how long the event clear is held.
// - Writing 1 clears the channel event history; the bit then returns to 0.
// - Reference enable, 1 at reset, selects the internal reference; 0 needs external.
// - Fourteen-bit sag time threshold in bits 0 to 13.
// - Aux pin carries clock when function bit is 0, zero-cross when 1; two-bit source.
// - Tamper runs only when enabled; tolerance 12.5, 8.33, 6.25, 3.125 percent.
// - Writing 1 to software reset restores every register default, then self-clears.
// - Writing 1 to a channel snapshot bit captures its measurements, then self-clears.
// - While auto latch is set, both channels are captured at 7.8125 kHz.
// - A pulse disable bit holds its pulse output low.
// - Total energy mode: sum of channel energies at 0, difference at 1.
// - Line frequency select: 50 Hz at 0, 60 Hz at 1.
// - Phase register: ten-bit current and two-bit voltage delays per channel, zero at reset.
// - Calibration: twelve-bit gain 0x800, surge threshold all ones, dip threshold zero.
// - Secondary current calibration: gain 0x800 and ten-bit surge threshold all ones.
package mdcb_pkg;

  localparam int          ADDR_W   = 12;
  localparam int          NUM_REGS = 8;
  localparam int          IDX_W    = 3;

  // Register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CH1_CFG  = 3'h0;
  localparam logic [IDX_W-1:0] IDX_CH2_CFG  = 3'h1;
  localparam logic [IDX_W-1:0] IDX_SAG_CTRL = 3'h2;
  localparam logic [IDX_W-1:0] IDX_PHASE    = 3'h3;
  localparam logic [IDX_W-1:0] IDX_V1_CAL   = 3'h4;
  localparam logic [IDX_W-1:0] IDX_HOLE     = 3'h5;
  localparam logic [IDX_W-1:0] IDX_V2_CAL   = 3'h6;
  localparam logic [IDX_W-1:0] IDX_C2_CAL   = 3'h7;

  localparam logic [31:0] REG_RESET [NUM_REGS] = '{
    32'h040000A0, 32'h040000A0, 32'h000004E0, 32'h00000000,
    32'h003FF800, 32'h00000000, 32'h003FF800, 32'h003FF800};
  localparam logic [31:0] REG_WMASK [NUM_REGS] = '{
    32'hFFFE00FF, 32'hFFFE00FF, 32'h0FFFFFFF, 32'h00FFFFFF,
    32'hFFFFFFFF, 32'h00000000, 32'hFFFFFFFF, 32'h003FFFFF};
  // Bits that software can only set and hardware clears
  localparam logic [31:0] REG_SELFCLR [NUM_REGS] = '{
    32'h00000010, 32'h00000010, 32'h00700000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};

  // Channel configuration register fields
  localparam int CLR_DUR_LSB = 0;
  localparam int CLR_DUR_W   = 4;
  localparam int HIST_CLR    = 4;
  localparam int REF_EN      = 5;
  localparam int REF_TC_LSB  = 6;
  localparam int AEM_BIT     = 17;
  localparam int APM_BIT     = 18;
  localparam int HPF_V_BIT   = 19;
  localparam int HPF_C_BIT   = 20;
  localparam int INTEG_BIT   = 21;
  localparam int BAND_V_BIT  = 22;
  localparam int BAND_C_BIT  = 23;
  localparam int DIV_LSB     = 24;
  localparam int QTY_LSB     = 28;
  localparam int SRC_LSB     = 30;

  // Sag, pin and tamper control fields
  localparam int TIME_LSB    = 0;
  localparam int TIME_W      = 14;
  localparam int AUX_SEL_LSB = 14;
  localparam int AUX_FN_BIT  = 16;
  localparam int TOL_LSB     = 17;
  localparam int TAMPER_DETECT_ENABLE_BIT  = 19;
  localparam int SWRST_BIT   = 20;
  localparam int SNAP1_BIT   = 21;
  localparam int SNAP2_BIT   = 22;
  localparam int AUTO_BIT    = 23;
  localparam int OFF1_BIT    = 24;
  localparam int OFF2_BIT    = 25;
  localparam int CUM_BIT     = 26;
  localparam int FREQ_BIT    = 27;

  // Phase and calibration fields
  localparam int PHC2_LSB  = 0;
  localparam int PHV2_LSB  = 10;
  localparam int CURRENT_PHASE_DELAY_LSB  = 12;
  localparam int VOLTAGE_PHASE_DELAY_LSB  = 22;
  localparam int GAIN_LSB  = 0;
  localparam int SURGE_LSB = 12;
  localparam int DIP_LSB   = 22;

  // Timing
  localparam longint CLK_HZ        = 25_000_000;
  localparam longint AUTO_RATE_MHZ = 7_812_500;   // 7.8125 kHz in millihertz
  localparam int     AUTO_CYC      = int'((CLK_HZ * 1000) / AUTO_RATE_MHZ);
  localparam int     AUTO_CNT_W    = 12;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } mdcb_apb_req_t;

  typedef struct packed {
    logic        apparent_energy_method;
    logic        vector_power_source;
    logic        voltage_highpass_bypass;
    logic        current_highpass_bypass;
    logic        coil_integrator_enable;
    logic        voltage_reactive_band;
    logic        current_reactive_band;
    logic [3:0]  pulse_rate_divider;
    logic [1:0]  pulse_quantity_select;
    logic [1:0]  pulse_source_select;
    logic        internal_reference_enable;
    logic [1:0]  reference_tc_select;
    logic [9:0]  current_phase_delay;
    logic [1:0]  voltage_phase_delay;
    logic [11:0] voltage_gain_calibrator;
    logic [9:0]  voltage_surge_threshold;
    logic [9:0]  voltage_dip_threshold;
  } mdcb_chan_cfg_t;

  typedef struct packed {
    logic [13:0] sag_time_threshold;
    logic [1:0]  aux_pin_source_select;
    logic        aux_pin_function;
    logic [1:0]  tamper_tolerance_select;
    logic        tamper_detect_enable;
    logic        total_energy_mode;
    logic        line_frequency_select;
    logic [11:0] current_gain_calibrator;
    logic [9:0]  current_surge_threshold;
  } mdcb_glob_cfg_t;

endpackage

/* src/mdcb_bank.sv */
// Metering DSP control bank: APB register file and its strobe and pulse logic.
// Assumes APB master on i_clock, inputs synchronous, DSP consuming the config structs.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module mdcb_bank (
  input  wire logic                       i_clock,
  input  wire logic                       i_nrst,
  input  wire mdcb_pkg::mdcb_apb_req_t    i_apb,
  output logic                            o_pready,
  output logic [31:0]                     o_prdata,
  output logic                            o_pslverr,
  input  wire logic [1:0]                 i_pulse_src,
  output logic [1:0]                      o_pulse_out,
  output logic [1:0]                      o_event_clear,
  output logic [1:0]                      o_snapshot,
  output mdcb_pkg::mdcb_chan_cfg_t [1:0]  o_chan_cfg,
  output mdcb_pkg::mdcb_glob_cfg_t        o_glob_cfg
);
  import mdcb_pkg::*;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a[1:0] == 2'h0) && (a[ADDR_W-1:IDX_W+2] == '0)
                  && (a[IDX_W+1:2] != IDX_HOLE);
  endfunction

  function automatic logic [IDX_W-1:0] addr_index(input logic [ADDR_W-1:0] a);
    addr_index = a[IDX_W+1:2];
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [31:0]           cfg_r     [NUM_REGS];
  logic [31:0]           cfg_nxt   [NUM_REGS];
  logic [NUM_REGS-1:0]   wr_hit;
  logic [NUM_REGS-1:0][31:0] hw_clr;
  logic                  pready_r;
  logic [31:0]           prdata_r;
  logic                  pslverr_r;
  logic [CLR_DUR_W-1:0]  clr_cnt_r [2];
  logic [1:0]            clr_done;
  logic [AUTO_CNT_W-1:0] auto_cnt_r;
  logic                  auto_tick;
  logic [1:0]            event_clear_r;
  logic [1:0]            snapshot_r;
  logic [1:0]            pulse_out_r;
  logic                  access;
  logic                  swrst;

  assign access = i_apb.psel && i_apb.penable && pready_r;
  assign swrst  = cfg_r[IDX_SAG_CTRL][SWRST_BIT];

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= i_apb.psel && i_apb.penable && !pready_r;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (i_apb.psel && i_apb.penable && !pready_r) begin
      pslverr_r <= !addr_mapped(i_apb.paddr);
      if (!i_apb.pwrite && addr_mapped(i_apb.paddr)) begin
        prdata_r <= cfg_r[addr_index(i_apb.paddr)];
      end else begin
        prdata_r <= 32'h00000000;
      end
    end else begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register update
  // ----------------------------------------
  // Hardware clears of self-clearing bits; a write setting the bit wins
  always_comb begin
    hw_clr = '0;
    hw_clr[IDX_CH1_CFG][HIST_CLR]   = clr_done[0];
    hw_clr[IDX_CH2_CFG][HIST_CLR]   = clr_done[1];
    hw_clr[IDX_SAG_CTRL][SNAP1_BIT] = 1'b1;
    hw_clr[IDX_SAG_CTRL][SNAP2_BIT] = 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      assign wr_hit[g] = access && i_apb.pwrite && addr_mapped(i_apb.paddr)
                         && (addr_index(i_apb.paddr) == IDX_W'(g));

      always_comb begin
        cfg_nxt[g] = cfg_r[g] & ~hw_clr[g];
        if (wr_hit[g]) begin
          // Reserved bits keep their value; self-clearing bits only set
          cfg_nxt[g] = (i_apb.pwdata & REG_WMASK[g] & ~REG_SELFCLR[g])
                     | (cfg_r[g] & ~REG_WMASK[g])
                     | ((cfg_r[g] & ~hw_clr[g]) & REG_SELFCLR[g])
                     | (i_apb.pwdata & REG_SELFCLR[g]);
        end
      end

      always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
          cfg_r[g] <= REG_RESET[g];
        end else if (swrst) begin
          cfg_r[g] <= REG_RESET[g];
        end else begin
          cfg_r[g] <= cfg_nxt[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Event history clear, held for duration + 1 cycles
  // ----------------------------------------
  generate
    for (g = 0; g < 2; g++) begin : g_clr
      assign clr_done[g] = cfg_r[g][HIST_CLR]
                           && (clr_cnt_r[g] == cfg_r[g][CLR_DUR_LSB +: CLR_DUR_W]);

      always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
          clr_cnt_r[g] <= '0;
        end else if (!cfg_r[g][HIST_CLR] || clr_done[g]) begin
          clr_cnt_r[g] <= '0;
        end else begin
          clr_cnt_r[g] <= clr_cnt_r[g] + 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      event_clear_r <= 2'h0;
    end else begin
      event_clear_r <= {cfg_r[IDX_CH2_CFG][HIST_CLR], cfg_r[IDX_CH1_CFG][HIST_CLR]};
    end
  end

  // ----------------------------------------
  // Snapshot strobes and automatic latch
  // ----------------------------------------
  assign auto_tick = cfg_r[IDX_SAG_CTRL][AUTO_BIT]
                     && (auto_cnt_r == AUTO_CNT_W'(AUTO_CYC - 1));

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      auto_cnt_r <= '0;
    end else if (!cfg_r[IDX_SAG_CTRL][AUTO_BIT] || auto_tick) begin
      auto_cnt_r <= '0;
    end else begin
      auto_cnt_r <= auto_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      snapshot_r <= 2'h0;
    end else begin
      snapshot_r <= {cfg_r[IDX_SAG_CTRL][SNAP2_BIT], cfg_r[IDX_SAG_CTRL][SNAP1_BIT]}
                    | {2{auto_tick}};
    end
  end

  // ----------------------------------------
  // Pulse outputs
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pulse_out_r <= 2'h0;
    end else begin
      pulse_out_r <= i_pulse_src & ~{cfg_r[IDX_SAG_CTRL][OFF2_BIT],
                                     cfg_r[IDX_SAG_CTRL][OFF1_BIT]};
    end
  end

  // ----------------------------------------
  // Configuration fields, straight from the registers
  // ----------------------------------------
  generate
    for (g = 0; g < 2; g++) begin : g_cfg
      always_comb begin
        o_chan_cfg[g].apparent_energy_method    = cfg_r[g][AEM_BIT];
        o_chan_cfg[g].vector_power_source       = cfg_r[g][APM_BIT];
        o_chan_cfg[g].voltage_highpass_bypass   = cfg_r[g][HPF_V_BIT];
        o_chan_cfg[g].current_highpass_bypass   = cfg_r[g][HPF_C_BIT];
        o_chan_cfg[g].coil_integrator_enable    = cfg_r[g][INTEG_BIT];
        o_chan_cfg[g].voltage_reactive_band     = cfg_r[g][BAND_V_BIT];
        o_chan_cfg[g].current_reactive_band     = cfg_r[g][BAND_C_BIT];
        o_chan_cfg[g].pulse_rate_divider        = cfg_r[g][DIV_LSB +: 4];
        o_chan_cfg[g].pulse_quantity_select     = cfg_r[g][QTY_LSB +: 2];
        o_chan_cfg[g].pulse_source_select       = cfg_r[g][SRC_LSB +: 2];
        o_chan_cfg[g].internal_reference_enable = cfg_r[g][REF_EN];
        o_chan_cfg[g].reference_tc_select       = cfg_r[g][REF_TC_LSB +: 2];
        if (g == 0) begin
          o_chan_cfg[g].current_phase_delay = cfg_r[IDX_PHASE][CURRENT_PHASE_DELAY_LSB +: 10];
          o_chan_cfg[g].voltage_phase_delay = cfg_r[IDX_PHASE][VOLTAGE_PHASE_DELAY_LSB +: 2];
          o_chan_cfg[g].voltage_gain_calibrator = cfg_r[IDX_V1_CAL][GAIN_LSB +: 12];
          o_chan_cfg[g].voltage_surge_threshold = cfg_r[IDX_V1_CAL][SURGE_LSB +: 10];
          o_chan_cfg[g].voltage_dip_threshold   = cfg_r[IDX_V1_CAL][DIP_LSB +: 10];
        end else begin
          o_chan_cfg[g].current_phase_delay = cfg_r[IDX_PHASE][PHC2_LSB +: 10];
          o_chan_cfg[g].voltage_phase_delay = cfg_r[IDX_PHASE][PHV2_LSB +: 2];
          o_chan_cfg[g].voltage_gain_calibrator = cfg_r[IDX_V2_CAL][GAIN_LSB +: 12];
          o_chan_cfg[g].voltage_surge_threshold = cfg_r[IDX_V2_CAL][SURGE_LSB +: 10];
          o_chan_cfg[g].voltage_dip_threshold   = cfg_r[IDX_V2_CAL][DIP_LSB +: 10];
        end
      end
    end
  endgenerate

  always_comb begin
    o_glob_cfg.sag_time_threshold      = cfg_r[IDX_SAG_CTRL][TIME_LSB +: TIME_W];
    o_glob_cfg.aux_pin_source_select   = cfg_r[IDX_SAG_CTRL][AUX_SEL_LSB +: 2];
    o_glob_cfg.aux_pin_function        = cfg_r[IDX_SAG_CTRL][AUX_FN_BIT];
    o_glob_cfg.tamper_tolerance_select = cfg_r[IDX_SAG_CTRL][TOL_LSB +: 2];
    o_glob_cfg.tamper_detect_enable    = cfg_r[IDX_SAG_CTRL][TAMPER_DETECT_ENABLE_BIT];
    o_glob_cfg.total_energy_mode       = cfg_r[IDX_SAG_CTRL][CUM_BIT];
    o_glob_cfg.line_frequency_select   = cfg_r[IDX_SAG_CTRL][FREQ_BIT];
    o_glob_cfg.current_gain_calibrator = cfg_r[IDX_C2_CAL][GAIN_LSB +: 12];
    o_glob_cfg.current_surge_threshold = cfg_r[IDX_C2_CAL][SURGE_LSB +: 10];
  end

  assign o_pready      = pready_r;
  assign o_prdata      = prdata_r;
  assign o_pslverr     = pslverr_r;
  assign o_event_clear = event_clear_r;
  assign o_snapshot    = snapshot_r;
  assign o_pulse_out   = pulse_out_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  apb_answer_a: assert property (
    i_apb.psel && i_apb.penable && !pready_r |=> pready_r)
    else $error("APB access not answered after one wait state");

  soft_reset_a: assert property (
    swrst |=> (cfg_r[IDX_V1_CAL] == REG_RESET[IDX_V1_CAL]) && !swrst
              && o_chan_cfg[0].internal_reference_enable)
    else $error("Software reset did not restore defaults");

  snap_strobe_a: assert property (
    cfg_r[IDX_SAG_CTRL][SNAP1_BIT] && !wr_hit[IDX_SAG_CTRL] && !swrst
    |=> o_snapshot[0] && !cfg_r[IDX_SAG_CTRL][SNAP1_BIT])
    else $error("Snapshot strobe missing or bit not self-cleared");

  auto_latch_a: assert property (
    auto_tick && !swrst |=> (o_snapshot == 2'h3) ##1 (auto_cnt_r == AUTO_CNT_W'(1)))
    else $error("Automatic snapshot not issued on period end");

  hist_clear_a: assert property (
    clr_done[0] && !wr_hit[IDX_CH1_CFG] && !swrst
    |=> !cfg_r[IDX_CH1_CFG][HIST_CLR] ##1 !o_event_clear[0])
    else $error("Event clear bit did not return to zero");

  clear_length_a: assert property (
    $rose(cfg_r[IDX_CH1_CFG][HIST_CLR])
    && (cfg_r[IDX_CH1_CFG][CLR_DUR_LSB +: CLR_DUR_W] == 4'h2) && !wr_hit[IDX_CH1_CFG]
    |-> ##1 (o_event_clear[0] && !swrst)[*3] |-> ##1 !o_event_clear[0])
    else $error("Event clear not held for duration plus one");

  pulse_off_a: assert property (
    o_pulse_out[1] |-> !$past(cfg_r[IDX_SAG_CTRL][OFF2_BIT]) && $past(i_pulse_src[1]))
    else $error("Disabled pulse output was driven");

  reserved_hold_a: assert property (
    ((cfg_r[IDX_SAG_CTRL] & ~REG_WMASK[IDX_SAG_CTRL]) == 32'h00000000)
    && (cfg_r[IDX_HOLE] == REG_RESET[IDX_HOLE]))
    else $error("Reserved bits changed");

endmodule

/* testbench/mdcb_bank_test.sv */
// Self-checking bench for the metering DSP control bank.
// Assumes the bank answers APB with one wait state and index 0 is channel one.
`timescale 1ns/1ns
module mdcb_bank_test;
  import mdcb_pkg::*;

  logic                     i_clock;
  logic                     i_nrst;
  mdcb_apb_req_t            apb;
  logic [1:0]               pulse_src;
  logic                     o_pready;
  logic [31:0]              o_prdata;
  logic                     o_pslverr;
  logic [1:0]               o_pulse_out;
  logic [1:0]               o_event_clear;
  logic [1:0]               o_snapshot;
  mdcb_chan_cfg_t [1:0]     o_chan_cfg;
  mdcb_glob_cfg_t           o_glob_cfg;
  int                       n_fail;
  int                       samples_checked;

  mdcb_bank mdcb_bank_i (
    .i_clock       (i_clock),
    .i_nrst        (i_nrst),
    .i_apb         (apb),
    .o_pready      (o_pready),
    .o_prdata      (o_prdata),
    .o_pslverr     (o_pslverr),
    .i_pulse_src   (pulse_src),
    .o_pulse_out   (o_pulse_out),
    .o_event_clear (o_event_clear),
    .o_snapshot    (o_snapshot),
    .o_chan_cfg    (o_chan_cfg),
    .o_glob_cfg    (o_glob_cfg)
  );

  // ---------------------------------------------------------------
  // Clock, verdict and bus tasks
  // ---------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Idles one cycle first so a release never meets a new setup in one step
  task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                          output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge i_clock);
    apb.psel    <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite  <= wr;
    apb.paddr   <= addr;
    apb.pwdata  <= wd;
    @(posedge i_clock);
    apb.penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    rd = o_prdata;
    err = o_pslverr;
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    apb.psel    <= 1'b0;
    apb.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb_xfer(1'b1, addr, wd, rd, err);
  endtask

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb_xfer(1'b0, addr, 32'h0, rd, err);
    chk("read data", exp, rd);
    chk("slave error", {31'h0, exp_err}, {31'h0, err});
  endtask

  task automatic count_high(input int cycles, output int c0, output int c1, input logic snap);
    c0 = 0;
    c1 = 0;
    repeat (cycles) begin
      @(posedge i_clock);
      c0 += snap ? int'(o_snapshot[0]) : int'(o_event_clear[0]);
      c1 += snap ? int'(o_snapshot[1]) : int'(o_event_clear[1]);
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults();
    for (int i = 0; i < NUM_REGS; i++)
      if (i != 5) rd_chk(12'(i * 4), REG_RESET[i], 1'b0);
    chk("divider", 32'h4, 32'(o_chan_cfg[0].pulse_rate_divider));
    chk("gain", 32'h800, 32'(o_chan_cfg[1].voltage_gain_calibrator));
  endtask

  // Reserved bits ignore writes; unmapped places refuse
  task automatic t_masks();
    logic [31:0] v;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (i == 5) continue;
      v = 32'hA5A5A5A5 & ~REG_SELFCLR[i];
      wr(12'(i * 4), v);
      rd_chk(12'(i * 4), (v & REG_WMASK[i]) | (REG_RESET[i] & ~REG_WMASK[i]), 1'b0);
    end
    wr(12'h014, 32'hFFFFFFFF);
    rd_chk(12'h014, 32'h0, 1'b1);
    rd_chk(12'h020, 32'h0, 1'b1);
    rd_chk(12'h002, 32'h0, 1'b1);
  endtask

  task automatic t_soft_reset();
    wr(12'h008, 32'h1 << SWRST_BIT);
    for (int i = 0; i < NUM_REGS; i++)
      if (i != 5) rd_chk(12'(i * 4), REG_RESET[i], 1'b0);
  endtask

  // Every code of the channel two and global mode and select fields except reference_tc_select reaches the outputs
  task automatic t_fields();
    logic [31:0] k;
    logic [1:0]  lo;
    logic [1:0]  hi;
    for (int j = 0; j < 4; j++) begin
      k = 32'(j);
      lo = {1'b0, k[0]};
      hi = {1'b0, k[1]};
      wr(12'h004, (k << SRC_LSB) | (k << QTY_LSB) | ((k + 32'h4) << DIV_LSB)
         | (32'(lo) << AEM_BIT) | (32'(hi) << APM_BIT) | (32'(lo) << HPF_V_BIT)
         | (32'(hi) << HPF_C_BIT) | (32'(lo) << INTEG_BIT) | (32'(lo) << BAND_V_BIT)
         | (32'(hi) << BAND_C_BIT) | (32'(hi) << REF_EN));
      @(posedge i_clock);
      chk("chan fields", {17'h0, k[0], k[1], k[0], k[1], k[0], k[0], k[1], 4'(k + 32'h4),
          k[1:0], k[1:0]}, {17'h0, o_chan_cfg[1][61:47]});
      chk("ref enable", {31'h0, k[1]}, {31'h0, o_chan_cfg[1].internal_reference_enable});
      wr(12'h008, (k << TOL_LSB) | (k << AUX_SEL_LSB) | (32'(lo) << AUX_FN_BIT)
         | (32'(hi) << TAMPER_DETECT_ENABLE_BIT) | (32'(lo) << CUM_BIT) | (32'(hi) << FREQ_BIT)
         | (32'h3FFF - k));
      @(posedge i_clock);
      chk("glob fields", {10'h0, 14'(32'h3FFF - k), k[1:0], k[0], k[1:0], k[1], k[0], k[1]},
          {10'h0, o_glob_cfg[43:22]});
      wr(12'h00C, (k << CURRENT_PHASE_DELAY_LSB) | (k << VOLTAGE_PHASE_DELAY_LSB) | ((32'h3FF - k) << PHC2_LSB)
         | ((32'h3 - k) << PHV2_LSB));
      wr(12'h018, 32'hFFFFFFFF - k);
      wr(12'h01C, 32'h003FFFFF - k);
      @(posedge i_clock);
      chk("phase one", {20'h0, 10'(k), k[1:0]}, {20'h0, o_chan_cfg[0].current_phase_delay,
          o_chan_cfg[0].voltage_phase_delay});
      chk("phase two", {20'h0, 10'(32'h3FF - k), 2'(32'h3 - k)}, {20'h0,
          o_chan_cfg[1].current_phase_delay, o_chan_cfg[1].voltage_phase_delay});
      chk("v2 cal", 32'hFFFFFFFF - k, {o_chan_cfg[1].voltage_dip_threshold,
          o_chan_cfg[1].voltage_surge_threshold, o_chan_cfg[1].voltage_gain_calibrator});
      chk("c2 cal", 32'h003FFFFF - k, {10'h0, o_glob_cfg.current_surge_threshold,
          o_glob_cfg.current_gain_calibrator});
    end
  endtask

  task automatic t_pulse_off();
    logic [1:0] off [3] = '{2'b01, 2'b10, 2'b00};
    pulse_src <= 2'b11;
    for (int j = 0; j < 3; j++) begin
      wr(12'h008, 32'(off[j]) << OFF1_BIT);
      repeat (3) @(posedge i_clock);
      chk("pulse out", {30'h0, ~off[j]}, {30'h0, o_pulse_out});
    end
    pulse_src <= 2'b01;
    repeat (3) @(posedge i_clock);
    chk("pulse out", 32'h1, {30'h0, o_pulse_out});
  endtask

  task automatic t_event_clear();
    int durs [4] = '{0, 3, 2, 15};
    int c0;
    int c1;
    for (int j = 0; j < 4; j++) begin
      wr(12'(4 * (j % 2)), REG_RESET[0] | 32'(durs[j]) | (32'h1 << HIST_CLR));
      count_high(30, c0, c1, 1'b0);
      chk("clear cycles", 32'(durs[j] + 1), 32'(j % 2 ? c1 : c0));
      chk("clear other", 32'h0, 32'(j % 2 ? c0 : c1));
      rd_chk(12'(4 * (j % 2)), REG_RESET[0] | 32'(durs[j]), 1'b0);
    end
  endtask

  task automatic t_snapshot();
    int c0;
    int c1;
    for (int ch = 0; ch < 2; ch++) begin
      wr(12'h008, 32'h1 << (SNAP1_BIT + ch));
      count_high(10, c0, c1, 1'b1);
      chk("snapshot own", 32'h1, 32'(ch ? c1 : c0));
      chk("snapshot other", 32'h0, 32'(ch ? c0 : c1));
      rd_chk(12'h008, 32'h0, 1'b0);
    end
  endtask

  task automatic t_auto_latch();
    int n;
    wr(12'h008, 32'h1 << AUTO_BIT);
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_snapshot !== 2'b11 && n < 4000);
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_snapshot !== 2'b11 && n < 4000);
    chk("auto period", 32'(AUTO_CYC), 32'(n));
    wr(12'h008, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    n_fail = 0;
    samples_checked = 0;
    apb = '0;
    pulse_src = 2'b00;
    i_nrst = 1'b0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    t_defaults();
    t_masks();
    t_soft_reset();
    t_fields();
    t_pulse_off();
    t_event_clear();
    t_snapshot();
    t_auto_latch();
    test_done();
  end

  // Whole run needs about seven thousand cycles
  initial begin
    #(40 * 40000);
    n_fail++;
    $display("MISMATCH watchdog expected done seen timeout");
    test_done();
  end
endmodule
